// >>> spf_serial_irq.sv
// Operation
// - tx flag rises when that channel's transmit buffer becomes empty.
// - rx flag rises when a complete character lands in the receive buffer.
// - flags read 0 idle, 1 pending; software may read and write them.
// - enable 0 blocks, 1 passes; order b tx, b rx, a tx, a rx.
// - second-pair enable resets to zero; bits 7..4 are plain storage.
// - second-pair flags reset tx=1, rx=0; bits 7..4 unused, read 0.
// - first-pair flags: only bits 3..0 driven here; upper bits read 0.
//
// Design decisions made here: the Avalon-MM register port and the address map.
module spf_serial_irq
  import spf_pkg::*;
(
  // clock and reset
  input  wire logic        SYS_CLK,
  input  wire logic        RST_N,
  // avalon-mm slave
  input  wire logic [7:0]  ADDRESS,
  input  wire logic        READ,
  input  wire logic        WRITE,
  input  wire logic [31:0] WRITEDATA,
  input  wire logic [3:0]  BYTEENABLE,
  output logic      [31:0] READDATA,
  output logic             WAITREQUEST,
  // channel events, index 0=a0 1=b0 2=a1 3=b1
  input  wire logic [3:0]  TX_BUF_EMPTY,
  input  wire logic [3:0]  RX_CHAR_DONE,
  // requests, bit 2c rx and 2c+1 tx of channel c
  output logic      [7:0]  CHAN_IRQ_REQ,
  output logic             IRQ
);
  logic [7:0]  flags;
  logic [7:0]  flag_set;
  logic [7:0]  flag_wr;
  logic [7:0]  flag_wdata;
  logic [3:0]  empty_d;
  logic [3:0]  empty_q;
  logic [3:0]  en_p0_d;
  logic [3:0]  en_p0_q;
  logic [7:0]  en_p1_d;
  logic [7:0]  en_p1_q;
  logic [7:0]  stat_d;
  logic [7:0]  stat_q;
  logic [7:0]  mask_d;
  logic [7:0]  mask_q;
  logic [7:0]  req_d;
  logic [7:0]  req_q;
  logic        irq_d;
  logic        irq_q;
  spf_bus_t    bus_d;
  spf_bus_t    bus_q;
  logic [31:0] rdata_d;
  logic [31:0] rdata_q;
  logic        wait_d;
  logic        wait_q;
  logic        wr_take;
  logic        wr_lo;
  logic [7:0]  rd_mux;

  // a write lands only on the edge where waitrequest is seen low
  assign wr_take = WRITE && (bus_q == SPF_BUS_ACK);
  assign wr_lo   = wr_take && BYTEENABLE[0];

  // one wait cycle per access keeps read data registered
  always_comb begin
    bus_d   = bus_q;
    rdata_d = rdata_q;
    case (bus_q)
      SPF_BUS_IDLE: begin
        if (READ || WRITE) begin
          bus_d   = SPF_BUS_ACK;
          rdata_d = {24'h00_0000, rd_mux};
        end
      end
      SPF_BUS_ACK: begin
        bus_d = SPF_BUS_IDLE;
      end
      default: begin
        bus_d = SPF_BUS_IDLE;
      end
    endcase
    // registered so the pin comes straight off a flop
    wait_d = (bus_d != SPF_BUS_ACK);
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      bus_q   <= SPF_BUS_IDLE;
      rdata_q <= SPF_RDATA_RST;
      wait_q  <= 1'b1;
    end else begin
      bus_q   <= bus_d;
      rdata_q <= rdata_d;
      wait_q  <= wait_d;
    end
  end

  // unmapped offsets read zero, writes ignored
  always_comb begin
    case (ADDRESS)
      SPF_OFS_FLAGS_P0: rd_mux = {4'h0, flags[3:0]};
      SPF_OFS_EN_P0:    rd_mux = {4'h0, en_p0_q};
      SPF_OFS_EN_P1:    rd_mux = en_p1_q;
      SPF_OFS_FLAGS_P1: rd_mux = {4'h0, flags[7:4]};
      SPF_OFS_IRQ_STAT: rd_mux = stat_q;
      SPF_OFS_IRQ_MASK: rd_mux = mask_q;
      default:          rd_mux = 8'h00;
    endcase
  end

  // tx set on the empty edge, so a software clear is not undone at once
  always_comb begin
    empty_d    = TX_BUF_EMPTY;
    flag_wdata = {WRITEDATA[3:0], WRITEDATA[3:0]};
    flag_wr    = 8'h00;
    if (wr_lo && ADDRESS == SPF_OFS_FLAGS_P0) begin
      flag_wr[3:0] = 4'hF;
    end
    if (wr_lo && ADDRESS == SPF_OFS_FLAGS_P1) begin
      flag_wr[7:4] = 4'hF;
    end
  end

  genvar c;
  generate
    for (c = 0; c < SPF_NCHAN; c++) begin : g_chan
      assign flag_set[2*c+SPF_POS_TX] =
        TX_BUF_EMPTY[c] && !empty_q[c];
      assign flag_set[2*c+SPF_POS_RX] = RX_CHAR_DONE[c];
    end
  endgenerate

  genvar f;
  generate
    for (f = 0; f < SPF_NFLAG; f++) begin : g_flag
      spf_flag_cell #(
        .RST_VAL (SPF_FLAGS_RST[f])
      ) u_cell (
        .clk   (SYS_CLK),
        .rst_n (RST_N),
        .set   (flag_set[f]),
        .wr    (flag_wr[f]),
        .wdata (flag_wdata[f]),
        .flag  (flags[f])
      );
    end
  endgenerate

  // enables, status and mask; status set wins over write-one-to-clear
  always_comb begin
    en_p0_d = en_p0_q;
    en_p1_d = en_p1_q;
    mask_d  = mask_q;
    stat_d  = stat_q;
    if (wr_lo && ADDRESS == SPF_OFS_EN_P0) begin
      en_p0_d = WRITEDATA[3:0];
    end
    if (wr_lo && ADDRESS == SPF_OFS_EN_P1) begin
      en_p1_d = WRITEDATA[7:0];
    end
    if (wr_lo && ADDRESS == SPF_OFS_IRQ_MASK) begin
      mask_d = WRITEDATA[7:0];
    end
    if (wr_lo && ADDRESS == SPF_OFS_IRQ_STAT) begin
      stat_d = stat_q & ~WRITEDATA[7:0];
    end
    stat_d = stat_d | flag_set;
    req_d  = flags & {en_p1_q[3:0], en_p0_q};
    irq_d  = |(stat_q & mask_q);
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      empty_q <= SPF_EMPTY_RST;
      en_p0_q <= SPF_EN_P0_RST;
      en_p1_q <= SPF_EN_P1_RST;
      stat_q  <= SPF_STAT_RST;
      mask_q  <= SPF_MASK_RST;
      req_q   <= 8'h00;
      irq_q   <= 1'b0;
    end else begin
      empty_q <= empty_d;
      en_p0_q <= en_p0_d;
      en_p1_q <= en_p1_d;
      stat_q  <= stat_d;
      mask_q  <= mask_d;
      req_q   <= req_d;
      irq_q   <= irq_d;
    end
  end

  assign READDATA     = rdata_q;
  assign WAITREQUEST  = wait_q;
  assign CHAN_IRQ_REQ = req_q;
  assign IRQ          = irq_q;

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);

  sequence s_p1_flag_write;
    wr_lo && ADDRESS == SPF_OFS_FLAGS_P1 && flag_set[7:4] == 4'h0;
  endsequence

  sequence s_access_start;
    (READ || WRITE) && bus_q == SPF_BUS_IDLE;
  endsequence

  a_tx_flag_set: assert property (
    TX_BUF_EMPTY[0] && !empty_q[0] |=> flags[SPF_POS_TX])
    else $error("tx flag not set after buffer went empty");

  a_rx_flag_set: assert property (
    RX_CHAR_DONE[3] |=> flags[6])
    else $error("rx flag not set after character done");

  a_flag_sw_write: assert property (
    s_p1_flag_write |=> flags[7:4] == $past(WRITEDATA[3:0]))
    else $error("software write to flags not stored");

  a_enable_gates_req: assert property (
    !en_p1_q[3] |=> !CHAN_IRQ_REQ[7])
    else $error("request passed a cleared enable");

  a_reset_values: assert property (
    disable iff (1'b0)
    !RST_N |=> en_p1_q == 8'h00 && flags == SPF_FLAGS_RST)
    else $error("wrong value after reset");

  a_p0_upper_zero: assert property (
    READ && bus_q == SPF_BUS_IDLE && ADDRESS == SPF_OFS_FLAGS_P0
    |=> READDATA[7:4] == 4'h0 && !WAITREQUEST)
    else $error("first pair upper flag bits not zero");

  a_req_and: assert property (
    ##1 CHAN_IRQ_REQ == $past(flags & {en_p1_q[3:0], en_p0_q}))
    else $error("request is not flag and enable");

  a_wait_one_cycle: assert property (
    s_access_start |-> WAITREQUEST ##1 !WAITREQUEST ##1 WAITREQUEST)
    else $error("waitrequest did not drop for exactly one cycle");

  a_irq_level: assert property (
    stat_q[0] && mask_q[0] |=> IRQ)
    else $error("interrupt not raised for unmasked status");

  a_irq_clear: assert property (
    (stat_q & mask_q) == 8'h00 |=> !IRQ)
    else $error("interrupt raised with nothing unmasked pending");

  genvar k;
  generate
    for (k = 0; k < SPF_NCHAN; k++) begin : g_chan_chk
      a_tx_edge_set: assert property (
        TX_BUF_EMPTY[k] && !empty_q[k] |=> flags[2*k+SPF_POS_TX])
        else $error("tx flag missed an empty edge");

      a_rx_stat_set: assert property (
        RX_CHAR_DONE[k] |=> flags[2*k+SPF_POS_RX] && stat_q[2*k+SPF_POS_RX])
        else $error("rx flag or status missed a character");
    end
  endgenerate

  sequence s_stat_clear0;
    wr_lo && ADDRESS == SPF_OFS_IRQ_STAT && WRITEDATA[0] && !flag_set[0];
  endsequence

  a_stat_w1c: assert property (
    s_stat_clear0 |=> !stat_q[0])
    else $error("status bit survived a write of one");

  sequence s_stat_hold0;
    stat_q[0] && !(wr_lo && ADDRESS == SPF_OFS_IRQ_STAT);
  endsequence

  a_stat_sticky: assert property (
    s_stat_hold0 |=> stat_q[0])
    else $error("status bit dropped without a clear");

  sequence s_blocked_write;
    WRITE && bus_q == SPF_BUS_ACK && !BYTEENABLE[0] && flag_set == 8'h00;
  endsequence

  a_be_guard: assert property (
    s_blocked_write |=> $stable(flags))
    else $error("flags changed on a write without byte enable 0");

  a_en_p0_store: assert property (
    wr_lo && ADDRESS == SPF_OFS_EN_P0 |=> en_p0_q == $past(WRITEDATA[3:0]))
    else $error("first-pair enable write not stored");

  a_en_p1_store: assert property (
    wr_lo && ADDRESS == SPF_OFS_EN_P1 |=> en_p1_q == $past(WRITEDATA[7:0]))
    else $error("second-pair enable write not stored");

  a_p1_upper_zero: assert property (
    READ && bus_q == SPF_BUS_IDLE && ADDRESS == SPF_OFS_FLAGS_P1
    |=> READDATA[31:4] == 28'h000_0000)
    else $error("second pair upper flag bits not zero");

  a_req_blocked: assert property (
    en_p0_q == 4'h0 && en_p1_q[3:0] == 4'h0 |=> CHAN_IRQ_REQ == 8'h00)
    else $error("request passed with all enables cleared");

  a_wait_idle: assert property (
    !READ && !WRITE && bus_q == SPF_BUS_IDLE |=> WAITREQUEST)
    else $error("waitrequest dropped with no access");

  a_rdata_upper_zero: assert property (
    !WAITREQUEST |-> READDATA[31:8] == 24'h00_0000)
    else $error("read data upper bytes not zero");
endmodule : spf_serial_irq

// >>> spf_pkg.sv
package spf_pkg;
  // byte offsets on the register bus
  localparam logic [7:0] SPF_OFS_FLAGS_P0 = 8'h00;
  localparam logic [7:0] SPF_OFS_EN_P0    = 8'h04;
  localparam logic [7:0] SPF_OFS_EN_P1    = 8'h08;
  localparam logic [7:0] SPF_OFS_FLAGS_P1 = 8'h0C;
  localparam logic [7:0] SPF_OFS_IRQ_STAT = 8'h10;
  localparam logic [7:0] SPF_OFS_IRQ_MASK = 8'h14;

  // field layout inside a pair register
  localparam int SPF_NCHAN   = 4;
  localparam int SPF_NFLAG   = 8;
  localparam int SPF_POS_RX  = 0;
  localparam int SPF_POS_TX  = 1;

  // reset values
  localparam logic [7:0] SPF_FLAGS_RST = 8'hAA;
  localparam logic [3:0] SPF_EN_P0_RST = 4'h0;
  localparam logic [7:0] SPF_EN_P1_RST = 8'h00;
  localparam logic [7:0] SPF_STAT_RST  = 8'h00;
  localparam logic [7:0] SPF_MASK_RST  = 8'h00;
  localparam logic [3:0] SPF_EMPTY_RST = 4'hF;
  localparam logic [31:0] SPF_RDATA_RST = 32'h0000_0000;

  typedef enum logic [0:0] {
    SPF_BUS_IDLE = 1'b0,
    SPF_BUS_ACK  = 1'b1
  } spf_bus_t;
endpackage : spf_pkg

// >>> spf_flag_cell.sv
module spf_flag_cell
  import spf_pkg::*;
#(
  parameter logic RST_VAL = 1'b0
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // hardware set, software write
  input  wire logic set,
  input  wire logic wr,
  input  wire logic wdata,
  // flag
  output logic      flag
);
  logic flag_d;
  logic flag_q;

  // set beats a software write in the same cycle
  always_comb begin
    flag_d = flag_q;
    if (wr) begin
      flag_d = wdata;
    end
    if (set) begin
      flag_d = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flag_q <= RST_VAL;
    end else begin
      flag_q <= flag_d;
    end
  end

  assign flag = flag_q;
endmodule : spf_flag_cell

// >>> tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import spf_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic        rd_en = 1'b0;
  logic        wr_en = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  be = 4'hF;
  logic [31:0] rdata;
  logic        waitreq;
  logic [3:0]  tx_empty = 4'hF;
  logic [3:0]  rx_done = 4'h0;
  logic [7:0]  req;
  logic        irq;
  logic [31:0] rd;
  int          n_mismatch = 0;
  int          samples_checked = 0;

  always #2 clk = ~clk;

  spf_serial_irq uut (
    .SYS_CLK(clk), .RST_N(rst_n), .ADDRESS(addr), .READ(rd_en),
    .WRITE(wr_en), .WRITEDATA(wdata), .BYTEENABLE(be),
    .READDATA(rdata), .WAITREQUEST(waitreq), .TX_BUF_EMPTY(tx_empty),
    .RX_CHAR_DONE(rx_done), .CHAN_IRQ_REQ(req), .IRQ(irq)
  );

  task automatic close_out;
    $display("mismatches %0d checked %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // request held until the edge that samples waitrequest low
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int i;
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    rd_en <= !w;
    wr_en <= w;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (waitreq === 1'b0) break;
    end
    if (i == 20) begin
      n_mismatch++;
      $display("[FAIL] %0t bus answer never came", $time);
      close_out();
    end
    rd = rdata;
    rd_en <= 1'b0;
    wr_en <= 1'b0;
  endtask : bus

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdchk

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask : wt

  task automatic t_reset;
    rdchk(SPF_OFS_FLAGS_P0, 32'h0A);
    rdchk(SPF_OFS_FLAGS_P1, 32'h0A);
    rdchk(SPF_OFS_EN_P1, 32'h00);
    rdchk(SPF_OFS_EN_P0, 32'h00);
    rdchk(SPF_OFS_IRQ_STAT, 32'h00);
    chk({23'h0, irq, req}, 32'h0);
  endtask : t_reset

  task automatic t_enables;
    bus(1'b1, SPF_OFS_EN_P1, 32'hFF);
    rdchk(SPF_OFS_EN_P1, 32'hFF);
    wt(2);
    chk({24'h0, req}, 32'hA0);
    bus(1'b1, SPF_OFS_EN_P1, 32'h08);
    wt(2);
    chk({24'h0, req}, 32'h80);
    bus(1'b1, SPF_OFS_EN_P1, 32'h00);
  endtask : t_enables

  task automatic t_rx_irq;
    @(posedge clk);
    rx_done <= 4'hF;
    @(posedge clk);
    rx_done <= 4'h0;
    rdchk(SPF_OFS_FLAGS_P0, 32'h0F);
    rdchk(SPF_OFS_FLAGS_P1, 32'h0F);
    bus(1'b1, SPF_OFS_EN_P0, 32'h01);
    wt(2);
    chk({24'h0, req}, 32'h01);
    rdchk(SPF_OFS_IRQ_STAT, 32'h55);
    bus(1'b1, SPF_OFS_IRQ_MASK, 32'h01);
    wt(2);
    chk({31'h0, irq}, 32'h1);
    bus(1'b1, SPF_OFS_IRQ_STAT, 32'h01);
    wt(2);
    chk({31'h0, irq}, 32'h0);
    rdchk(SPF_OFS_IRQ_STAT, 32'h54);
  endtask : t_rx_irq

  task automatic t_soft_tx;
    bus(1'b1, SPF_OFS_FLAGS_P0, 32'hF0);
    rdchk(SPF_OFS_FLAGS_P0, 32'h00);
    wt(1);
    chk({24'h0, req}, 32'h00);
    @(posedge clk);
    tx_empty <= 4'h0;
    wt(2);
    tx_empty <= 4'hF;
    wt(2);
    rdchk(SPF_OFS_FLAGS_P0, 32'h0A);
    rdchk(SPF_OFS_IRQ_STAT, 32'hFE);
    // low byte disabled: write must not land
    be <= 4'hE;
    bus(1'b1, SPF_OFS_FLAGS_P0, 32'h0F);
    be <= 4'hF;
    rdchk(SPF_OFS_FLAGS_P0, 32'h0A);
    bus(1'b1, SPF_OFS_FLAGS_P1, 32'hF0);
    rdchk(SPF_OFS_FLAGS_P1, 32'h00);
    rdchk(8'h20, 32'h00);
  endtask : t_soft_tx

  initial begin
    wt(12);
    rst_n <= 1'b1;
    t_reset();
    t_enables();
    t_rx_irq();
    t_soft_tx();
    close_out();
  end
endmodule : tb
